// ===== logic/fce_exchange.sv
// container exchange between fieldbus master and the station gateway
// What this block does
// - acyclic response type and selector echo
// - flag illegal selector, command, access error
// - busy high while processing; contents invalid then
// - acyclic words: address, index, read value
// - toggle out is inverted toggle in
// - forward control word on each cyclic-selector request when enabled
// - cyclic answer within the same master cycle
// - cyclic echo selector, online, valid flags
// - cyclic words: value, status, address, zeros
// - default mode status bit layout
// - trigger mode status bit layout
// - dosing mode status bit layout
`timescale 1ns/1ps
`include "fce_defines.svh"

module fce_exchange (
  input  wire logic                CLK,
  input  wire logic                RESET,
  // ==========================================
  // master side
  input  wire logic                REQ_VALID,
  input  wire fce_pkg::fce_ry_t    RY,
  input  wire logic [63:0]         RWW,
  output fce_pkg::fce_rx_t         RX,
  output logic      [63:0]         RWR,
  // ==========================================
  // station side, cyclic
  input  wire logic                ALL_ONLINE,
  input  wire logic [1:0]          INPUT_FUNCTION_MODE,
  input  wire fce_pkg::fce_stn_t   STN,
  output logic      [7:0]          STN_ADDR,
  output logic                     STN_CTRL_VALID,
  output logic      [15:0]         STN_CTRL_WORD,
  // ==========================================
  // station side, acyclic parameter access
  output logic                     PAR_REQ,
  output logic                     PAR_WRITE,
  output logic      [7:0]          PAR_ADDR,
  output logic      [15:0]         PAR_INDEX,
  output logic      [31:0]         PAR_WDATA,
  input  wire logic                PAR_DONE,
  input  wire logic                PAR_ERR,
  input  wire logic [31:0]         PAR_RDATA
);

  // ==========================================
  // request capture
  fce_pkg::fce_ry_t       req_q;
  logic [63:0]            wrd_q;
  logic                   pend_q;
  fce_pkg::fce_acc_state_t acc_q;
  logic                   acc_write_q;
  logic [15:0]            status;
  fce_pkg::fce_rx_t       rx_d;
  logic [63:0]            rwr_d;
  logic                   upd_d;
  fce_pkg::fce_acc_state_t acc_d;
  logic                   start_d;
  fce_pkg::fce_acyc_t     acyc;
  fce_pkg::fce_cyc_t      cyc;
  logic                   cmd_legal;
  logic                   cmd_rw;

  // the master keeps its request stable, so one capture per cycle suffices
  // request sampled once per master cycle
  always_ff @(posedge CLK) begin
    if (RESET) begin
      req_q <= '0;
      wrd_q <= 64'h0000_0000_0000_0000;
    end else if (REQ_VALID) begin
      req_q <= RY;
      wrd_q <= RWW;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= REQ_VALID;
    end
  end

  // ==========================================
  // station addressing and control word forwarding
  always_ff @(posedge CLK) begin
    if (RESET) begin
      STN_ADDR <= 8'h00;
    end else if (REQ_VALID) begin
      STN_ADDR <= RWW[7:0];
    end
  end

  // control word sent on every enabled request with a cyclic selector
  always_ff @(posedge CLK) begin
    if (RESET) begin
      STN_CTRL_VALID <= 1'b0;
      STN_CTRL_WORD  <= 16'h0000;
    end else begin
      STN_CTRL_VALID <= REQ_VALID && RY.control_word_enable &&
                        (RY.sel == `FCE_SEL_MEAS || RY.sel == `FCE_SEL_TRIG ||
                         RY.sel == `FCE_SEL_DOSE);
      if (REQ_VALID) begin
        STN_CTRL_WORD <= RWW[31:16];
      end
    end
  end

  // ==========================================
  // status word for the current mode
  fce_status_fmt fce_status_fmt_i (
    .mode   (INPUT_FUNCTION_MODE),
    .f      (STN.flags),
    .status (status)
  );

  // ==========================================
  // response composition
  assign cmd_rw    = (req_q.sdo_cmd == `FCE_CMD_READ) ||
                     (req_q.sdo_cmd == `FCE_CMD_WRITE);
  assign cmd_legal = cmd_rw || (req_q.sdo_cmd == `FCE_CMD_IDLE);

  always_comb begin
    rx_d    = RX;
    rwr_d   = RWR;
    upd_d   = 1'b0;
    acc_d   = acc_q;
    start_d = 1'b0;
    acyc    = '0;
    cyc     = '0;
    acyc.addr  = wrd_q[7:0];
    acyc.index = wrd_q[31:16];
    acyc.value = PAR_RDATA;
    cyc.addr   = STN_ADDR[6:0];
    cyc.status = status;
    if (acc_q == fce_pkg::FCE_ACC_WAIT && PAR_DONE) begin
      // busy drops with the result in place
      upd_d          = 1'b1;
      acc_d          = fce_pkg::FCE_ACC_DONE;
      rx_d.busy      = 1'b0;
      rx_d.access_err = PAR_ERR;
      rx_d.rsp_type  = acc_write_q ? `FCE_RSP_WRITE : `FCE_RSP_READ;
      rwr_d          = acc_write_q ? RWR : 64'(acyc);
    end else if (pend_q) begin
      upd_d = 1'b1;
      rx_d  = '0;
      rwr_d = `FCE_RWR_RESET;
      // toggle written with the rest of the answer
      rx_d.toggle_out = ~req_q.toggle_in;
      unique case (req_q.sel)
        `FCE_SEL_IDLE: begin
          rx_d.sel = `FCE_SEL_IDLE;
        end
        `FCE_SEL_PARAM: begin
          rx_d.sel = `FCE_SEL_PARAM;
          rwr_d    = 64'(acyc);
          if (!cmd_legal) begin
            rx_d.illegal_cmd = 1'b1;
          end else if (acc_q == fce_pkg::FCE_ACC_DONE) begin
            if (req_q.sdo_cmd == `FCE_CMD_IDLE) begin
              rx_d.rsp_type = `FCE_RSP_END;
              acc_d         = fce_pkg::FCE_ACC_IDLE;
            end else begin
              rx_d            = RX;
              rwr_d           = RWR;
              rx_d.toggle_out = ~req_q.toggle_in;
            end
          end else if (acc_q == fce_pkg::FCE_ACC_WAIT) begin
            // stays busy over several master cycles
            rx_d.busy = 1'b1;
          end else if (cmd_rw) begin
            // busy from the start of processing
            rx_d.busy = 1'b1;
            acc_d     = fce_pkg::FCE_ACC_WAIT;
            start_d   = 1'b1;
          end
        end
        // cyclic answer built from current station data
        `FCE_SEL_MEAS: begin
          rx_d.sel        = `FCE_SEL_MEAS;
          rx_d.data_valid = STN.meas_valid;
          cyc.value       = STN.measured_value;
        end
        `FCE_SEL_TRIG: begin
          rx_d.sel        = `FCE_SEL_TRIG;
          rx_d.data_valid = STN.trig_valid;
          cyc.value       = STN.trigger_result;
        end
        `FCE_SEL_DOSE: begin
          rx_d.sel        = `FCE_SEL_DOSE;
          rx_d.data_valid = STN.dose_valid;
          cyc.value       = STN.dosing_result;
        end
        default: begin
          // illegal selector is echoed and flagged
          rx_d.sel         = req_q.sel;
          rx_d.illegal_sel = 1'b1;
        end
      endcase
      if (req_q.sel == `FCE_SEL_MEAS || req_q.sel == `FCE_SEL_TRIG ||
          req_q.sel == `FCE_SEL_DOSE) begin
        // online flag with the cyclic echo
        rx_d.all_online = ALL_ONLINE;
        rwr_d           = 64'(cyc);
      end
    end
  end

  // ==========================================
  // response registers
  always_ff @(posedge CLK) begin
    if (RESET) begin
      RX  <= `FCE_RX_RESET;
      RWR <= `FCE_RWR_RESET;
    end else if (upd_d) begin
      RX  <= rx_d;
      RWR <= rwr_d;
    end
  end

  // ==========================================
  // acyclic access sequencer
  always_ff @(posedge CLK) begin
    if (RESET) begin
      acc_q       <= fce_pkg::FCE_ACC_IDLE;
      acc_write_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      if (start_d) begin
        acc_write_q <= (req_q.sdo_cmd == `FCE_CMD_WRITE);
      end
    end
  end

  // value is passed whole as 32 bits whatever the parameter width
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PAR_REQ   <= 1'b0;
      PAR_WRITE <= 1'b0;
      PAR_ADDR  <= 8'h00;
      PAR_INDEX <= 16'h0000;
      PAR_WDATA <= 32'h0000_0000;
    end else begin
      PAR_REQ <= start_d;
      if (start_d) begin
        PAR_WRITE <= (req_q.sdo_cmd == `FCE_CMD_WRITE);
        PAR_ADDR  <= wrd_q[7:0];
        PAR_INDEX <= wrd_q[31:16];
        PAR_WDATA <= wrd_q[63:32];
      end
    end
  end

endmodule : fce_exchange

// ===== logic/fce_defines.svh
// constants of the fieldbus container exchange: codes, field positions, resets
`ifndef FCE_DEFINES_SVH
`define FCE_DEFINES_SVH

// ==========================================
// selector codes, request and response
`define FCE_SEL_IDLE      4'h0
`define FCE_SEL_PARAM     4'h3
`define FCE_SEL_MEAS      4'h4
`define FCE_SEL_TRIG      4'h5
`define FCE_SEL_DOSE      4'h6

// ==========================================
// acyclic command and response-type codes
`define FCE_CMD_IDLE      4'h0
`define FCE_CMD_READ      4'h1
`define FCE_CMD_WRITE     4'h2
`define FCE_RSP_IDLE      4'h0
`define FCE_RSP_READ      4'h1
`define FCE_RSP_WRITE     4'h2
`define FCE_RSP_END       4'h3

// ==========================================
// input function modes
`define FCE_MODE_DEFAULT  2'h0
`define FCE_MODE_TRIGGER  2'h1
`define FCE_MODE_DOSING   2'h2

// ==========================================
// status word bit positions (word bit 0 is word-area bit 32)
`define FCE_ST_ESR        15
`define FCE_ST_IN2        14
`define FCE_ST_EXC        13
`define FCE_ST_SHORT      12
`define FCE_ST_B11        11
`define FCE_ST_B10        10
`define FCE_ST_LFT        9
`define FCE_ST_B8         8
`define FCE_ST_OVF        7
`define FCE_ST_B6         6
`define FCE_ST_B5         5
`define FCE_ST_B4         4
`define FCE_ST_B3         3
`define FCE_ST_B2         2
`define FCE_ST_B1         1
`define FCE_ST_B0         0

// ==========================================
// reset values
`define FCE_RX_RESET      16'h0000
`define FCE_RWR_RESET     64'h0000_0000_0000_0000

`endif

// ===== logic/fce_pkg.sv
// types of the fieldbus container exchange
package fce_pkg;

  // ==========================================
  // request bit area as the master drives it
  typedef struct packed {
    logic [3:0] unused;
    logic [3:0] sdo_cmd;
    logic       toggle_in;
    logic [1:0] zero;
    logic       control_word_enable;
    logic [3:0] sel;
  } fce_ry_t;

  // ==========================================
  // response bit area
  typedef struct packed {
    logic       busy;
    logic       spare14;
    logic       access_err;
    logic       illegal_cmd;
    logic [3:0] rsp_type;
    logic       toggle_out;
    logic       data_valid;
    logic       all_online;
    logic       illegal_sel;
    logic [3:0] sel;
  } fce_rx_t;

  // ==========================================
  // word areas
  typedef struct packed {
    logic [31:0] value;
    logic [15:0] index;
    logic [7:0]  zero;
    logic [7:0]  addr;
  } fce_acyc_t;

  typedef struct packed {
    logic [8:0]  zero;
    logic [6:0]  addr;
    logic [15:0] status;
    logic [31:0] value;
  } fce_cyc_t;

  // ==========================================
  // station condition flags
  typedef struct packed {
    logic error_status_fault;
    logic input_two;
    logic input_one;
    logic excitation_fault;
    logic output_short;
    logic second_range_flag;
    logic range_overrun_flag;
    logic true_zero;
    logic overflow;
    logic limit_value_one;
    logic limit_value_two;
    logic standstill_flag;
    logic gross;
    logic zero_done_flag;
    logic trigger_active_flag;
    logic trigger_available;
    logic lower_tolerance_error;
    logic upper_tolerance_error;
    logic dosing_time_overrun;
    logic alarm_output_flag;
    logic fill_flow;
    logic emptying_active;
    logic redosing_active;
    logic dosing_ready;
    logic fine_fill_flow;
    logic coarse_fill_flow;
  } fce_flags_t;

  // ==========================================
  // data of the currently addressed station
  typedef struct packed {
    logic [31:0] measured_value;
    logic [31:0] trigger_result;
    logic [31:0] dosing_result;
    logic        meas_valid;
    logic        trig_valid;
    logic        dose_valid;
    fce_flags_t  flags;
  } fce_stn_t;

  typedef enum logic [1:0] {
    FCE_ACC_IDLE = 2'b00,
    FCE_ACC_WAIT = 2'b01,
    FCE_ACC_DONE = 2'b10
  } fce_acc_state_t;

endpackage : fce_pkg

// ===== logic/fce_status_fmt.sv
// formats the 16-bit value status word for the active input function mode
`timescale 1ns/1ps
`include "fce_defines.svh"

module fce_status_fmt (
  input  wire logic [1:0]         mode,
  input  wire fce_pkg::fce_flags_t f,
  output logic      [15:0]        status
);

  always_comb begin
    status = 16'h0000;
    status[`FCE_ST_ESR]   = f.error_status_fault;
    status[`FCE_ST_EXC]   = f.excitation_fault;
    status[`FCE_ST_SHORT] = f.output_short;
    status[`FCE_ST_OVF]   = f.overflow;
    status[`FCE_ST_LFT]   = f.range_overrun_flag;
    unique case (mode)
      `FCE_MODE_TRIGGER: begin
        status[`FCE_ST_IN2] = f.input_two;
        status[`FCE_ST_B11] = f.zero_done_flag;
        status[`FCE_ST_B10] = f.second_range_flag;
        status[`FCE_ST_B8]  = f.true_zero;
        status[`FCE_ST_B6]  = f.trigger_active_flag;
        status[`FCE_ST_B5]  = f.limit_value_two;
        status[`FCE_ST_B4]  = f.limit_value_one;
        status[`FCE_ST_B3]  = f.standstill_flag;
        status[`FCE_ST_B2]  = f.trigger_available;
        status[`FCE_ST_B1]  = f.input_one;
        status[`FCE_ST_B0]  = f.gross;
      end
      `FCE_MODE_DOSING: begin
        status[`FCE_ST_IN2] = f.input_one;
        status[`FCE_ST_B11] = f.lower_tolerance_error;
        status[`FCE_ST_B10] = f.upper_tolerance_error;
        status[`FCE_ST_B8]  = f.dosing_time_overrun;
        status[`FCE_ST_B6]  = f.alarm_output_flag;
        status[`FCE_ST_B5]  = f.fill_flow;
        status[`FCE_ST_B4]  = f.emptying_active;
        status[`FCE_ST_B3]  = f.redosing_active;
        status[`FCE_ST_B2]  = f.dosing_ready;
        status[`FCE_ST_B1]  = f.fine_fill_flow;
        status[`FCE_ST_B0]  = f.coarse_fill_flow;
      end
      // default layout; unused code 3 falls back here too
      default: begin
        status[`FCE_ST_IN2] = f.input_two;
        status[`FCE_ST_B10] = f.second_range_flag;
        status[`FCE_ST_B8]  = f.true_zero;
        status[`FCE_ST_B6]  = f.second_range_flag;
        status[`FCE_ST_B5]  = f.limit_value_two;
        status[`FCE_ST_B4]  = f.limit_value_one;
        status[`FCE_ST_B3]  = f.standstill_flag;
        status[`FCE_ST_B2]  = f.input_one;
        status[`FCE_ST_B1]  = f.true_zero;
        status[`FCE_ST_B0]  = f.gross;
      end
    endcase
  end

endmodule : fce_status_fmt

// ===== testbench/fce_master_model.sv
// fieldbus master model: one request per master cycle, held until the next
`timescale 1ns/1ps

module fce_master_model (
  input  wire logic        CLK,
  output logic             REQ_VALID,
  output fce_pkg::fce_ry_t RY,
  output logic [63:0]      RWW
);
  initial begin
    REQ_VALID = 1'b0;
    RY = '0;
    RWW = '0;
  end

  task automatic send(input fce_pkg::fce_ry_t ry, input logic [63:0] ww);
    @(negedge CLK);
    RY = ry;
    RWW = ww;
    REQ_VALID = 1'b1;
    @(negedge CLK);
    REQ_VALID = 1'b0;
    repeat (2) @(negedge CLK);
  endtask : send
endmodule : fce_master_model

// ===== testbench/fce_exchange_asserts.sv
// timing checks on the ports of the container exchange
`timescale 1ns/1ps

module fce_exchange_asserts (
  input wire logic             CLK,
  input wire logic             RESET,
  input wire logic             REQ_VALID,
  input wire fce_pkg::fce_ry_t RY,
  input wire logic [63:0]      RWW,
  input wire fce_pkg::fce_rx_t RX,
  input wire logic [63:0]      RWR,
  input wire logic             STN_CTRL_VALID,
  input wire logic [15:0]      STN_CTRL_WORD,
  input wire logic             PAR_REQ,
  input wire logic             PAR_WRITE,
  input wire logic [15:0]      PAR_INDEX,
  input wire logic             PAR_DONE,
  input wire logic             PAR_ERR,
  input wire logic [31:0]      PAR_RDATA
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence cyc_req_s;
    REQ_VALID && RY.sel inside {4'h4, 4'h5, 4'h6};
  endsequence
  sequence done_s;
    PAR_DONE;
  endsequence

  toggle_invert_a: assert property (cyc_req_s |-> ##2 RX.toggle_out == !$past(RY.toggle_in, 2))
    else $error("toggle out not inverted");
  cyc_echo_a: assert property (cyc_req_s |-> ##2 RX.sel == $past(RY.sel, 2) && !RX.busy)
    else $error("cyclic selector echo wrong");
  illegal_sel_a: assert property (
    REQ_VALID && !(RY.sel inside {4'h0, 4'h3, 4'h4, 4'h5, 4'h6}) |-> ##2 RX.illegal_sel)
    else $error("illegal selector not flagged");
  cyc_words_a: assert property (
    cyc_req_s |-> ##2 RWR[63:55] == 9'h000 && RWR[54:48] == $past(RWW[6:0], 2))
    else $error("cyclic address field wrong");
  ctrl_fwd_a: assert property (
    cyc_req_s ##0 RY.control_word_enable |=> STN_CTRL_VALID && STN_CTRL_WORD == $past(RWW[31:16]))
    else $error("control word not forwarded");
  ctrl_cause_a: assert property (
    STN_CTRL_VALID |-> $past(REQ_VALID) && $past(RY.control_word_enable))
    else $error("control word sent unasked");
  par_start_a: assert property (
    PAR_REQ |-> RX.busy && $past(REQ_VALID, 2) && $past(RY.sel, 2) == 4'h3)
    else $error("parameter access without request");
  done_rsp_a: assert property (done_s |=> !RX.busy && RX.sel == 4'h3
    && RX.rsp_type == ($past(PAR_WRITE) ? 4'h2 : 4'h1) && RX.access_err == $past(PAR_ERR))
    else $error("completion response wrong");
  read_word_a: assert property (done_s ##0 !PAR_WRITE |=> RWR[63:32] == $past(PAR_RDATA)
    && RWR[15:8] == 8'h00 && RWR[31:16] == PAR_INDEX)
    else $error("read response words wrong");
endmodule : fce_exchange_asserts

bind fce_exchange fce_exchange_asserts fce_exchange_asserts_i (.CLK, .RESET, .REQ_VALID, .RY,
  .RWW, .RX, .RWR, .STN_CTRL_VALID, .STN_CTRL_WORD, .PAR_REQ, .PAR_WRITE, .PAR_INDEX,
  .PAR_DONE, .PAR_ERR, .PAR_RDATA);

// ===== testbench/fce_exchange_tb.sv
// self-checking bench of the container exchange with station stand-in
`timescale 1ns/1ps

module fce_exchange_tb;
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic              req_valid, all_online, ctrl_valid, par_req, par_write, par_done, par_err;
  logic [1:0]        mode, seen_q = 2'b00;
  logic [4:0]        cnt_q = 5'h00;
  logic [7:0]        stn_addr, par_addr;
  logic [15:0]       ctrl_word, par_index;
  logic [31:0]       base, par_wdata, par_rdata, mv;
  logic [63:0]       rww, rwr, p;
  logic [159:0]      e;
  fce_pkg::fce_ry_t  ry;
  fce_pkg::fce_rx_t  rx;
  fce_pkg::fce_stn_t stn;
  logic [159:0]      exp_q[$];
  logic [63:0]       par_q[$];
  int                failures = 0, total_checks = 0, cycles = 0, seed = 83559;

  always #5 clk = ~clk;

  fce_master_model fce_master_model_i (.CLK(clk), .REQ_VALID(req_valid), .RY(ry), .RWW(rww));
  fce_exchange fce_exchange_i (
    .CLK(clk), .RESET(reset), .REQ_VALID(req_valid), .RY(ry), .RWW(rww), .RX(rx), .RWR(rwr),
    .ALL_ONLINE(all_online), .INPUT_FUNCTION_MODE(mode), .STN(stn), .STN_ADDR(stn_addr),
    .STN_CTRL_VALID(ctrl_valid), .STN_CTRL_WORD(ctrl_word), .PAR_REQ(par_req),
    .PAR_WRITE(par_write), .PAR_ADDR(par_addr), .PAR_INDEX(par_index), .PAR_WDATA(par_wdata),
    .PAR_DONE(par_done), .PAR_ERR(par_err), .PAR_RDATA(par_rdata));

  // ==========================================
  // station stand-in
  assign mv = {base[31:8], stn_addr};
  assign stn = {mv, ~mv, mv ^ 32'hFFFF_0000, base[2:0], base[25:0]};
  always @(posedge clk) begin
    if (par_req)
      cnt_q <= {3'h0, base[4:3]} + 5'h02;
    else if (cnt_q != 5'h00)
      cnt_q <= cnt_q - 5'h01;
  end
  assign par_done = (cnt_q == 5'h01);
  // read data and error flip outside the done cycle so a stale sample shows
  assign par_rdata = par_done ? ~base : base;
  assign par_err = par_done ? base[5] : ~base[5];

  // ==========================================
  // expectations
  // status mask in the upper half, status in the lower; unlisted bits stay masked
  function automatic logic [31:0] stexp(input logic [1:0] m, input fce_pkg::fce_flags_t f);
    case (m)
      2'h1: return {16'hF8FF, f.error_status_fault, f.input_two, f.excitation_fault,
        f.output_short, f.zero_done_flag, 3'h0, f.overflow, f.trigger_active_flag,
        f.limit_value_two, f.limit_value_one, f.standstill_flag, f.trigger_available,
        f.input_one, f.gross};
      2'h2: return {16'hBDFF, f.error_status_fault, 1'b0, f.excitation_fault, f.output_short,
        f.lower_tolerance_error, f.upper_tolerance_error, 1'b0, f.dosing_time_overrun,
        f.overflow, f.alarm_output_flag, f.fill_flow, f.emptying_active, f.redosing_active,
        f.dosing_ready, f.fine_fill_flow, f.coarse_fill_flow};
      default: return {16'hF0BD, f.error_status_fault, f.input_two, f.excitation_fault,
        f.output_short, 4'h0, f.overflow, 1'b0, f.limit_value_two, f.limit_value_one,
        f.standstill_flag, f.input_one, 1'b0, f.gross};
    endcase
  endfunction : stexp

  task automatic cmp64(input logic [63:0] got, input logic [63:0] m, input logic [63:0] x);
    total_checks++;
    if ((got & m) !== (x & m)) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got & m, x & m);
    end
  endtask : cmp64

  task automatic cmp16(input logic [15:0] got, input logic [15:0] m, input logic [15:0] x);
    cmp64({48'h0, got}, {48'h0, m}, {48'h0, x});
  endtask : cmp16

  task automatic cyc(input logic [3:0] sel, input logic [7:0] a);
    logic tin, ok, hit;
    logic [31:0] s, v, m;
    tin = 1'($random(seed));
    base = $random(seed);
    mode = base[8:7];
    all_online = base[30];
    m = {base[31:8], a};
    hit = sel inside {4'h4, 4'h5, 4'h6};
    ok = (sel == 4'h4) ? base[2] : (sel == 4'h5) ? base[1] : base[0];
    v = (sel == 4'h4) ? m : (sel == 4'h5) ? ~m : m ^ 32'hFFFF_0000;
    s = stexp(mode, base[25:0]);
    exp_q.push_back({hit ? 16'h80FF : 16'h809F,
      {8'h00, ~tin, ok, all_online, !(hit || sel == 4'h0 || sel == 4'h3), sel},
      hit ? {16'hFFFF, s[31:16], 32'hFFFF_FFFF} : 64'h0, {9'h000, a[6:0], s[15:0], v}});
    fce_master_model_i.send({8'h00, tin, 2'b00, base[9], sel}, {32'h0, base[29:14], 8'h00, a});
  endtask : cyc

  task automatic acyc(input logic [3:0] cmd, input logic [7:0] a, input logic [15:0] ix);
    int n;
    base = $random(seed);
    if (cmd < 4'h3)
      par_q.push_back({7'h00, cmd == 4'h2, a, ix, base});
    exp_q.push_back({cmd < 4'h3 ? 32'h800F_8003 : 32'h100F_1003, 128'h0});
    fce_master_model_i.send({4'h0, cmd, 8'h03}, {base, ix, 8'h00, a});
    if (cmd > 4'h2)
      return;
    n = 0;
    while (par_done !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n == 40)
      failures++;
    exp_q.push_back({16'hBF8F, {2'b00, base[5], 1'b0, cmd, 8'h03},
      cmd == 4'h1 ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0, {~base, ix, 8'h00, a}});
    fce_master_model_i.send({4'h0, cmd, 8'h83}, {base, ix, 8'h00, a});
    exp_q.push_back({32'h8F0F_0303, 128'h0});
    fce_master_model_i.send(16'h0003, {base, ix, 8'h00, a});
    exp_q.push_back({32'h8F00_0000, 128'h0});
    fce_master_model_i.send(16'h0083, {base, ix, 8'h00, a});
  endtask : acyc

  // ==========================================
  // monitor: each answer is settled one edge after the edge behind the request
  always @(posedge clk) begin
    seen_q <= {seen_q[0], req_valid};
    cycles++;
    if (cycles == 5000) begin
      failures++;
      give_verdict();
    end
  end

  always @(negedge clk) begin
    if (seen_q[1] === 1'b1) begin
      e = exp_q.pop_front();
      cmp16(rx, e[159:144], e[143:128]);
      cmp64(rwr, e[127:64], e[63:0]);
    end
    if (ctrl_valid === 1'b1)
      cmp16(ctrl_word, 16'hFFFF, rww[31:16]);
    if (par_req === 1'b1) begin
      p = par_q.pop_front();
      cmp64({7'h00, par_write, par_addr, par_index, par_wdata}, '1, p);
    end
  end

  task automatic give_verdict();
    if (failures == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  initial begin
    all_online = 1'b0;
    mode = 2'h0;
    base = 32'h0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    for (int i = 0; i < 16; i++)
      cyc(4'(i), 8'(i * 8 + 1));
    cyc(4'h4, 8'h80);
    repeat (40)
      cyc(4'h4 + 4'($unsigned($random(seed)) % 3), 8'($random(seed)));
    acyc(4'h1, 8'h80, 16'h0001);
    acyc(4'h2, 8'h01, 16'h0044);
    acyc(4'h7, 8'h02, 16'h0009);
    repeat (6)
      acyc(4'h1 + 4'($unsigned($random(seed)) % 2), 8'($random(seed)), 16'($random(seed)));
    repeat (4) @(negedge clk);
    give_verdict();
  end
endmodule : fce_exchange_tb
